// File: core/tmrov_defs.svh
/*
 * Timer block constants: register offsets, field positions, reset values and divider counts.
 * Assumes inclusion by bare name from files under core/.
 */
`ifndef TMROV_DEFS_SVH
`define TMROV_DEFS_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define TMROV_ADDR_CLKCTL   8'h00
`define TMROV_ADDR_MODE     8'h04
`define TMROV_ADDR_T0       8'h08
`define TMROV_ADDR_T1       8'h0c
`define TMROV_ADDR_T2       8'h10
`define TMROV_ADDR_T2RLD    8'h14
`define TMROV_ADDR_T3       8'h18
`define TMROV_ADDR_T3RLD    8'h1c
`define TMROV_ADDR_CAP2     8'h20
`define TMROV_ADDR_CAP3     8'h24
`define TMROV_ADDR_STATUS   8'h28
`define TMROV_ADDR_MASK     8'h2c

// ----------------------------------------
// Clock control fields
// ----------------------------------------
`define TMROV_CK_SCA_LSB    0
`define TMROV_CK_T0SEL      2
`define TMROV_CK_T1SEL      3
`define TMROV_CK_T2L        4
`define TMROV_CK_T2H        5
`define TMROV_CK_T3L        6
`define TMROV_CK_T3H        7

// ----------------------------------------
// Mode register fields
// ----------------------------------------
`define TMROV_MD_T0MODE     0
`define TMROV_MD_T0CNT      2
`define TMROV_MD_T0RUN      3
`define TMROV_MD_T1MODE     4
`define TMROV_MD_T1CNT      6
`define TMROV_MD_T1RUN      7
`define TMROV_MD_T2RUN      8
`define TMROV_MD_T2SPLIT    9
`define TMROV_MD_T2XSEL     10
`define TMROV_MD_T2CAP      12
`define TMROV_MD_T3RUN      16
`define TMROV_MD_T3SPLIT    17
`define TMROV_MD_T3XSEL     18
`define TMROV_MD_T3CAP      20

// ----------------------------------------
// Reset values and divider counts
// ----------------------------------------
`define TMROV_RST_CLKCTL    8'h00
`define TMROV_RST_MODE      32'h0000_0000
`define TMROV_DIV4          4
`define TMROV_DIV8          8
`define TMROV_DIV12         12
`define TMROV_DIV48         48

`endif

// File: core/tmrov_pkg.sv
/*
 * Timer block types: prescale and source encodings, status layout.
 * Assumes tmrov_defs.svh constants are used alongside.
 */
package tmrov_pkg;

    // ----------------------------------------
    // Encodings
    // ----------------------------------------
    typedef enum logic [1:0] {
        TMROV_PRE_DIV12 = 2'b00,
        TMROV_PRE_DIV4  = 2'b01,
        TMROV_PRE_DIV48 = 2'b10,
        TMROV_PRE_EXT8  = 2'b11
    } tmrov_pre_type;

    typedef enum logic [1:0] {
        TMROV_M13    = 2'b00,
        TMROV_M16    = 2'b01,
        TMROV_M8RLD  = 2'b10,
        TMROV_MSPLIT = 2'b11
    } tmrov_mode_type;

    // Extra source for timers 2 and 3
    typedef enum logic [1:0] {
        TMROV_X_DIV12 = 2'b00,
        TMROV_X_OSC8  = 2'b01,
        TMROV_X_CMP   = 2'b10,
        TMROV_X_RSV   = 2'b11
    } tmrov_xsel_type;

    // ----------------------------------------
    // Status bits
    // ----------------------------------------
    typedef struct packed {
        logic t3_cap;
        logic t3_low;
        logic t3_high;
        logic t2_cap;
        logic t2_low;
        logic t2_high;
        logic t1_ovf;
        logic t0_low;
        logic t0_ovf;
    } tmrov_stat_type;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [31:0] wdata;
    } tmrov_bus_type;

endpackage

// File: core/tmrov_timers.sv
/*
 * Four 16-bit counter/timers with clock selection, event counting and capture.
 * Assumes one 25 MHz clock; count pins, oscillator and comparator inputs are asynchronous.
 */
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "tmrov_defs.svh"

// Functional notes
// - Four 16-bit counter/timers: two classic ones and two auto-reload ones.
// - Timers 0 and 1 run 13-bit, 16-bit or 8-bit auto-reload; split 8-bit is for timer 0 only.
// - Timers 2 and 3 run as one 16-bit auto-reload timer or two 8-bit auto-reload timers.
// - Timer 2 captures the period of the slow oscillator divided by eight, timer 3 that of the comparator 1 output.
// - Timers 0 and 1 pick the prescaled clock or the system clock with their select bit.
// - Timers 2 and 3 run on the system clock or the system clock divided by twelve.
// - Timer 2 can also run on the slow oscillator divided by eight or comparator 0.
// - Timer 3 can also run on the external oscillator divided by eight or comparator 1.
// - In counter mode timers 0 and 1 step on each falling edge of their count input.
// - Event counting keeps up with inputs up to a quarter of the system clock rate.
// - Prescale field: 00 is div 12, 01 div 4, 10 div 48, 11 external clock div 8.
// - Select bit 1 counts system clocks, 0 the prescaled clock; ignored in counter mode.
module tmrov_timers #(
    parameter int W = 16
) (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst_n,
    // Register port
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr_stb,
    input  wire logic        rd_stb,
    output logic [31:0]      rdata,
    // Asynchronous sources
    input  wire logic        count_input_zero,
    input  wire logic        count_input_one,
    input  wire logic        ext_osc,
    input  wire logic        rtc_osc,
    input  wire logic        cmp0_out,
    input  wire logic        cmp1_out,
    // Interrupt
    output logic             irq
);

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    // Index: 0 cnt0, 1 cnt1, 2 ext, 3 rtc, 4 cmp0, 5 cmp1
    logic [5:0] async_in;
    logic [5:0] s1_q;
    logic [5:0] s2_q;
    logic [5:0] s3_q;
    logic [5:0] lvl_q;
    logic [5:0] fall;

    assign async_in = {cmp1_out, cmp0_out, rtc_osc, ext_osc, count_input_one, count_input_zero};

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s1_q  <= 6'h3f;
            s2_q  <= 6'h3f;
            s3_q  <= 6'h3f;
            lvl_q <= 6'h3f;
        end else begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            // A change counts once stages two and three agree
            lvl_q <= (s2_q & s3_q) | (lvl_q & ~(~s2_q & ~s3_q));
        end
    end

    // One-cycle strobe per falling edge; two-clock levels keep pace at sys_clk_a/4
    assign fall = lvl_q & ~((s2_q & s3_q) | (lvl_q & ~(~s2_q & ~s3_q)));

    // ----------------------------------------
    // Dividers
    // ----------------------------------------
    logic [5:0] d12_q;
    logic [5:0] d4_q;
    logic [5:0] d48_q;
    logic [2:0] ext8_q;
    logic [2:0] rtc8_q;
    logic       tick12;
    logic       tick4;
    logic       tick48;
    logic       ext8;
    logic       rtc8;

    function automatic logic wrap(input logic [5:0] cnt, input int n);
        wrap = (cnt == 6'(n - 1));
    endfunction

    assign tick12 = wrap(d12_q, `TMROV_DIV12);
    assign tick4  = wrap(d4_q, `TMROV_DIV4);
    assign tick48 = wrap(d48_q, `TMROV_DIV48);
    assign ext8   = fall[2] && (ext8_q == 3'h7);
    assign rtc8   = fall[3] && (rtc8_q == 3'h7);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            d12_q  <= 6'h00;
            d4_q   <= 6'h00;
            d48_q  <= 6'h00;
            ext8_q <= 3'h0;
            rtc8_q <= 3'h0;
        end else begin
            d12_q  <= tick12 ? 6'h00 : d12_q + 6'h01;
            d4_q   <= tick4 ? 6'h00 : d4_q + 6'h01;
            d48_q  <= tick48 ? 6'h00 : d48_q + 6'h01;
            ext8_q <= ext8_q + 3'(fall[2]);
            rtc8_q <= rtc8_q + 3'(fall[3]);
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [7:0]                 clkctl_q;
    logic [31:0]                mode_q;
    logic [W-1:0]               cnt_q [4];
    logic [W-1:0]               rld_q [2];
    logic [W-1:0]               cap_q [2];
    tmrov_pkg::tmrov_stat_type  stat_q;
    tmrov_pkg::tmrov_stat_type  mask_q;
    tmrov_pkg::tmrov_stat_type  ev;
    tmrov_pkg::tmrov_pre_type   pre;
    logic                       pre_tick;

    assign pre = tmrov_pkg::tmrov_pre_type'(clkctl_q[`TMROV_CK_SCA_LSB +: 2]);

    always_comb begin
        case (pre)
            tmrov_pkg::TMROV_PRE_DIV12: pre_tick = tick12;
            tmrov_pkg::TMROV_PRE_DIV4:  pre_tick = tick4;
            tmrov_pkg::TMROV_PRE_DIV48: pre_tick = tick48;
            default:                    pre_tick = ext8;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            clkctl_q <= `TMROV_RST_CLKCTL;
            mode_q   <= `TMROV_RST_MODE;
        end else if (wr_stb) begin
            if (addr == `TMROV_ADDR_CLKCTL) begin
                clkctl_q <= wdata[7:0];
            end else if (addr == `TMROV_ADDR_MODE) begin
                mode_q <= wdata;
            end
        end
    end

    // ----------------------------------------
    // Timers 0 and 1
    // ----------------------------------------
    logic [1:0] step01;
    logic       step0h;
    logic [W-1:0] nxt01 [2];
    logic [1:0] ovf01;
    logic       ovf0h;

    generate
        for (genvar i = 0; i < 2; i++) begin : g_t01
            localparam int B = i * 4;
            logic tclk;
            tmrov_pkg::tmrov_mode_type md;
            assign md = tmrov_pkg::tmrov_mode_type'(mode_q[B +: 2]);
            // Select bit ignored in counter mode
            assign tclk = mode_q[B + 2] ? fall[i]
                        : (clkctl_q[`TMROV_CK_T0SEL + i] ? 1'b1 : pre_tick);
            assign step01[i] = mode_q[B + 3] && tclk;
            always_comb begin
                nxt01[i] = cnt_q[i];
                ovf01[i] = 1'b0;
                case (md)
                    tmrov_pkg::TMROV_M13: begin
                        nxt01[i][12:0] = cnt_q[i][12:0] + 13'h1;
                        ovf01[i] = &cnt_q[i][12:0];
                    end
                    tmrov_pkg::TMROV_M16: begin
                        nxt01[i] = cnt_q[i] + 16'h1;
                        ovf01[i] = &cnt_q[i];
                    end
                    tmrov_pkg::TMROV_M8RLD: begin
                        ovf01[i] = &cnt_q[i][7:0];
                        nxt01[i][7:0] = ovf01[i] ? cnt_q[i][15:8] : cnt_q[i][7:0] + 8'h1;
                    end
                    default: begin
                        // Timer 1 holds in split mode; timer 0 low byte counts alone
                        if (i == 0) begin
                            nxt01[i][7:0] = cnt_q[i][7:0] + 8'h1;
                            ovf01[i] = &cnt_q[i][7:0];
                        end
                    end
                endcase
            end
        end
    endgenerate

    // Timer 0 high byte in split mode runs on timer 1's run bit and the timer clock
    assign step0h = (mode_q[1:0] == 2'b11) && mode_q[`TMROV_MD_T1RUN]
                  && (clkctl_q[`TMROV_CK_T0SEL] ? 1'b1 : pre_tick);
    assign ovf0h  = step0h && (&cnt_q[0][15:8]);

    // ----------------------------------------
    // Timers 2 and 3
    // ----------------------------------------
    logic [1:0] ovf_lo;
    logic [1:0] ovf_hi;
    logic [1:0] cap_ev;

    generate
        for (genvar j = 0; j < 2; j++) begin : g_t23
            localparam int B = 8 + j * 8;
            logic xclk;
            logic cap_src;
            logic clk_lo;
            logic clk_hi;
            logic run;
            tmrov_pkg::tmrov_xsel_type xs;
            assign xs  = tmrov_pkg::tmrov_xsel_type'(mode_q[B + 2 +: 2]);
            assign run = mode_q[B];
            // Timer 2 gets the slow oscillator, timer 3 the external one
            always_comb begin
                case (xs)
                    tmrov_pkg::TMROV_X_OSC8: xclk = (j == 0) ? rtc8 : ext8;
                    tmrov_pkg::TMROV_X_CMP:  xclk = fall[4 + j];
                    default:                 xclk = tick12;
                endcase
            end
            assign clk_lo = clkctl_q[`TMROV_CK_T2L + 2 * j] ? 1'b1 : xclk;
            assign clk_hi = clkctl_q[`TMROV_CK_T2H + 2 * j] ? 1'b1 : xclk;
            // In capture mode the timer runs on its own clock and the edge of the measured source latches it
            assign cap_src   = (j == 0) ? rtc8 : fall[5];
            assign cap_ev[j] = run && mode_q[B + 4] && cap_src;
            assign ovf_lo[j] = run && clk_lo && (&cnt_q[2 + j][7:0]);
            assign ovf_hi[j] = run && (mode_q[B + 1] ? clk_hi && (&cnt_q[2 + j][15:8])
                                                   : clk_lo && (&cnt_q[2 + j]));

            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    cnt_q[2 + j] <= 16'h0000;
                    rld_q[j]     <= 16'h0000;
                    cap_q[j]     <= 16'h0000;
                end else begin
                    if (cap_ev[j]) begin
                        cap_q[j] <= cnt_q[2 + j];
                    end
                    if (wr_stb && addr == (`TMROV_ADDR_T2RLD + 8'(j * 8))) begin
                        rld_q[j] <= wdata[15:0];
                    end
                    if (wr_stb && addr == (`TMROV_ADDR_T2 + 8'(j * 8))) begin
                        cnt_q[2 + j] <= wdata[15:0];
                    end else if (run && mode_q[B + 1]) begin
                        // Split: each byte reloads from its own reload byte
                        if (clk_lo) begin
                            cnt_q[2 + j][7:0] <= ovf_lo[j] ? rld_q[j][7:0] : cnt_q[2 + j][7:0] + 8'h1;
                        end
                        if (clk_hi) begin
                            cnt_q[2 + j][15:8] <= ovf_hi[j] ? rld_q[j][15:8] : cnt_q[2 + j][15:8] + 8'h1;
                        end
                    end else if (run && clk_lo) begin
                        cnt_q[2 + j] <= ovf_hi[j] ? rld_q[j] : cnt_q[2 + j] + 16'h1;
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q[0] <= 16'h0000;
            cnt_q[1] <= 16'h0000;
        end else begin
            // Software writes win over a step in the same cycle
            if (wr_stb && addr == `TMROV_ADDR_T0) begin
                cnt_q[0] <= wdata[15:0];
            end else begin
                if (step01[0]) begin
                    cnt_q[0][7:0] <= nxt01[0][7:0];
                    if (mode_q[1:0] != 2'b11) begin
                        cnt_q[0][15:8] <= nxt01[0][15:8];
                    end
                end
                if (step0h) begin
                    cnt_q[0][15:8] <= cnt_q[0][15:8] + 8'h1;
                end
            end
            if (wr_stb && addr == `TMROV_ADDR_T1) begin
                cnt_q[1] <= wdata[15:0];
            end else if (step01[1]) begin
                cnt_q[1] <= nxt01[1];
            end
        end
    end

    // ----------------------------------------
    // Status, mask and interrupt
    // ----------------------------------------
    assign ev = '{t3_cap:  cap_ev[1],
                  t3_low:  ovf_lo[1] && mode_q[`TMROV_MD_T3SPLIT],
                  t3_high: ovf_hi[1],
                  t2_cap:  cap_ev[0],
                  t2_low:  ovf_lo[0] && mode_q[`TMROV_MD_T2SPLIT],
                  t2_high: ovf_hi[0],
                  t1_ovf:  step01[1] && ovf01[1],
                  t0_low:  ovf0h,
                  t0_ovf:  step01[0] && ovf01[0]};

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            stat_q <= '0;
            mask_q <= '0;
        end else begin
            // A new event in the read cycle stays set
            if (rd_stb && addr == `TMROV_ADDR_STATUS) begin
                stat_q <= ev;
            end else begin
                stat_q <= stat_q | ev;
            end
            if (wr_stb && addr == `TMROV_ADDR_MASK) begin
                mask_q <= wdata[8:0];
            end
        end
    end

    assign irq = |(stat_q & mask_q);

    // ----------------------------------------
    // Read port
    // ----------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 32'h0000_0000;
        end else if (rd_stb) begin
            if (addr == `TMROV_ADDR_CLKCTL) begin
                rdata <= {24'h000000, clkctl_q};
            end else if (addr == `TMROV_ADDR_MODE) begin
                rdata <= mode_q;
            end else if (addr == `TMROV_ADDR_T0) begin
                rdata <= {16'h0000, cnt_q[0]};
            end else if (addr == `TMROV_ADDR_T1) begin
                rdata <= {16'h0000, cnt_q[1]};
            end else if (addr == `TMROV_ADDR_T2) begin
                rdata <= {16'h0000, cnt_q[2]};
            end else if (addr == `TMROV_ADDR_T2RLD) begin
                rdata <= {16'h0000, rld_q[0]};
            end else if (addr == `TMROV_ADDR_T3) begin
                rdata <= {16'h0000, cnt_q[3]};
            end else if (addr == `TMROV_ADDR_T3RLD) begin
                rdata <= {16'h0000, rld_q[1]};
            end else if (addr == `TMROV_ADDR_CAP2) begin
                rdata <= {16'h0000, cap_q[0]};
            end else if (addr == `TMROV_ADDR_CAP3) begin
                rdata <= {16'h0000, cap_q[1]};
            end else if (addr == `TMROV_ADDR_STATUS) begin
                rdata <= {23'h000000, stat_q};
            end else if (addr == `TMROV_ADDR_MASK) begin
                rdata <= {23'h000000, mask_q};
            end else begin
                rdata <= 32'h0000_0000;
            end
        end
    end

endmodule
`default_nettype wire

// File: sim/tmrov_event_src.sv
/* Far-side model: one asynchronous count or comparator pin sending bursts of falls.
   Assumes the bench calls send from one process at a time. */
`timescale 1ns/1ps
`default_nettype none
module tmrov_event_src (
    // Clock
    input  wire logic clock,
    // Event pin, idles high
    output logic      pin
);
    initial pin = 1'b1;

    // Levels held two or three clocks: the short pairs run at a quarter of the clock
    task automatic send(input int n);
        for (int i = 0; i < 2 * n; i++) begin
            @(posedge clock);
            pin <= ~pin;
            repeat (1 + (i % 4) / 2) @(posedge clock);
        end
    endtask
endmodule
`default_nettype wire

// File: sim/tmrov_timers_chk.sv
/* Checker: register read-back, idle counts, interrupt level.
   Assumes it is bound to the top module and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
`include "tmrov_defs.svh"
module tmrov_timers_chk (
    // Clock and reset
    input wire logic        clock,
    input wire logic        rst_n,
    // Register port
    input wire logic [7:0]  addr,
    input wire logic [31:0] wdata,
    input wire logic        wr_stb,
    input wire logic        rd_stb,
    input wire logic [31:0] rdata,
    // Pin and interrupt
    input wire logic        count_input_zero,
    input wire logic        irq
);
    logic [7:0]  clk_q;
    logic [31:0] mode_q;
    logic [8:0]  mask_q;
    logic [15:0] t0_q;
    logic [15:0] t2_q;
    logic        t0_ok_q;
    logic        t2_ok_q;
    logic        pin_q;
    wire logic   wr_mode = wr_stb && addr == `TMROV_ADDR_MODE;
    wire logic   fall0   = pin_q && !count_input_zero;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            clk_q  <= 8'h00;
            mode_q <= 32'h0;
            mask_q <= 9'h000;
            pin_q  <= 1'b1;
        end else begin
            pin_q <= count_input_zero;
            if (wr_stb && addr == `TMROV_ADDR_CLKCTL) clk_q <= wdata[7:0];
            if (wr_mode) mode_q <= wdata;
            if (wr_stb && addr == `TMROV_ADDR_MASK) mask_q <= wdata[8:0];
        end
    end

    // A count is taken as known from a write until a mode write starts it or the raw pin falls; split high-byte steps are not seen
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            t0_ok_q <= 1'b0;
            t2_ok_q <= 1'b0;
            t0_q    <= 16'h0000;
            t2_q    <= 16'h0000;
        end else begin
            if (wr_stb && addr == `TMROV_ADDR_T0) begin
                t0_q    <= wdata[15:0];
                t0_ok_q <= !mode_q[3] || mode_q[2];
            end else if ((wr_mode && wdata[3] && !wdata[2]) || (mode_q[2] && fall0)) begin
                t0_ok_q <= 1'b0;
            end
            if (wr_stb && addr == `TMROV_ADDR_T2) begin
                t2_q    <= wdata[15:0];
                t2_ok_q <= !mode_q[8];
            end else if (wr_mode && wdata[8]) begin
                t2_ok_q <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_t0_idle_hold: assert property (rd_stb && addr == `TMROV_ADDR_T0 && t0_ok_q |=> rdata[15:0] == t0_q)
        else $error("T0 moved with no clock or event");
    a_t2_idle_hold: assert property (rd_stb && addr == `TMROV_ADDR_T2 && t2_ok_q |=> rdata[15:0] == t2_q)
        else $error("T2 moved while stopped");
    a_clk_readback: assert property (rd_stb && addr == `TMROV_ADDR_CLKCTL |=> rdata == {24'h0, clk_q})
        else $error("Clock control read-back wrong");
    a_mode_readback: assert property (rd_stb && addr == `TMROV_ADDR_MODE
        |=> (rdata & 32'h001f_1fff) == (mode_q & 32'h001f_1fff))
        else $error("Mode read-back wrong");
    a_count_width: assert property (rd_stb && addr >= 8'h08 && addr <= 8'h24 |=> rdata[31:16] == 16'h0)
        else $error("Count wider than 16 bits");
    a_unmapped_zero: assert property (rd_stb && addr > 8'h2c |=> rdata == 32'h0)
        else $error("Unmapped read not zero");
    a_irq_masked: assert property (mask_q == 9'h000 |-> !irq)
        else $error("Interrupt with all sources masked");
    a_irq_status: assert property (rd_stb && addr == `TMROV_ADDR_STATUS
        |=> (|(rdata[8:0] & mask_q)) == $past(irq))
        else $error("Interrupt level disagrees with status");
endmodule

bind tmrov_timers tmrov_timers_chk u_chk (
    .clock            (clock),
    .rst_n            (rst_n),
    .addr             (addr),
    .wdata            (wdata),
    .wr_stb           (wr_stb),
    .rd_stb           (rd_stb),
    .rdata            (rdata),
    .count_input_zero (count_input_zero),
    .irq              (irq)
);
`default_nettype wire

// File: sim/tb_tmrov_timers.sv
/* Bench: reset values, read-back, clock sources, event counting, overflow and interrupt.
   Assumes the event source model and the bound checker are compiled with it. */
`timescale 1ns/1ps
`default_nettype none
`include "tmrov_defs.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
    $display("Error %0t: got %h expected %h", $time, (g), (e)); end end
module tb_tmrov_timers;
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        wr_stb = 1'b0;
    logic        rd_stb = 1'b0;
    logic        ext_osc = 1'b0;
    logic [31:0] rdata;
    logic        irq;
    wire  [3:0]  pin;
    logic [31:0] d;
    logic [31:0] x;
    logic [15:0] v [4];
    int          n [4];
    int          n_fail = 0;
    int          cmp_count = 0;
    int          seed = 57364;
    logic [7:0]  ta [4] = '{`TMROV_ADDR_T0, `TMROV_ADDR_T1, `TMROV_ADDR_T2, `TMROV_ADDR_T3};
    logic [7:0]  tr [6] = '{`TMROV_ADDR_T0, `TMROV_ADDR_T1, `TMROV_ADDR_T2,
                            `TMROV_ADDR_T2RLD, `TMROV_ADDR_T3, `TMROV_ADDR_T3RLD};

    always #20 clock = ~clock;
    // Five clocks a period keeps every oscillator level sampled
    always #100 ext_osc <= ~ext_osc;

    tmrov_timers dut (
        .clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
        .count_input_zero(pin[0]), .count_input_one(pin[1]), .ext_osc(ext_osc),
        .rtc_osc(ext_osc), .cmp0_out(pin[2]), .cmp1_out(pin[3]), .irq(irq)
    );
    tmrov_event_src src0 (.clock(clock), .pin(pin[0]));
    tmrov_event_src src1 (.clock(clock), .pin(pin[1]));
    tmrov_event_src src2 (.clock(clock), .pin(pin[2]));
    tmrov_event_src src3 (.clock(clock), .pin(pin[3]));

    function automatic logic near(input logic [31:0] got, input int exp, input int tol);
        return (int'(got) >= exp - tol) && (int'(got) <= exp + tol);
    endfunction

    task automatic wr(input logic [7:0] a, input logic [31:0] dat);
        @(posedge clock);
        addr   <= a;
        wdata  <= dat;
        wr_stb <= 1'b1;
        @(posedge clock);
        wr_stb <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        addr   <= a;
        rd_stb <= 1'b1;
        @(posedge clock);
        rd_stb <= 1'b0;
        #1 d = rdata;
    endtask

    // Start edge of the run is not exact, hence the tolerance
    task automatic measure(input logic [7:0] ck, input logic [7:0] a, input logic [31:0] md, input int div);
        wr(`TMROV_ADDR_CLKCTL, {24'h0, ck});
        wr(a, 32'h0);
        wr(`TMROV_ADDR_MODE, md);
        repeat (480) @(posedge clock);
        wr(`TMROV_ADDR_MODE, 32'h0);
        rd(a);
        `CHK(near(d, 480 / div, (div == 1) ? 4 : 2), 1'b1)
    endtask

    task automatic done(input string s);
        $display("Test %s finished", s);
    endtask

    task automatic close_out;
        $display("Compares %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Whole run needs about 5200 clocks
    initial begin
        #(40 * 30000);
        n_fail++;
        close_out();
    end

    initial begin
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        rd(`TMROV_ADDR_CLKCTL);
        `CHK(d, 32'h0)
        rd(`TMROV_ADDR_MODE);
        `CHK(d, 32'h0)
        rd(`TMROV_ADDR_STATUS);
        `CHK(d, 32'h0)
        `CHK(irq, 1'b0)
        done("reset");
        for (int k = 0; k < 12; k++) begin
            x = $random(seed);
            wr(tr[k % 6], x);
            rd(tr[k % 6]);
            `CHK(d, ({16'h0, x[15:0]}))
        end
        wr(8'h30, x);
        rd(8'h30);
        `CHK(d, 32'h0)
        wr(`TMROV_ADDR_CAP2, x);
        rd(`TMROV_ADDR_CAP2);
        `CHK(d, 32'h0)
        done("readback");
        measure(8'h00, `TMROV_ADDR_T0, 32'h09, 12);
        measure(8'h01, `TMROV_ADDR_T0, 32'h09, 4);
        measure(8'h02, `TMROV_ADDR_T0, 32'h09, 48);
        measure(8'h03, `TMROV_ADDR_T0, 32'h09, 40);
        measure(8'h04, `TMROV_ADDR_T0, 32'h09, 1);
        measure(8'h08, `TMROV_ADDR_T1, 32'h90, 1);
        measure(8'h00, `TMROV_ADDR_T2, 32'h100, 12);
        measure(8'h40, `TMROV_ADDR_T3, 32'h10000, 1);
        measure(8'h00, `TMROV_ADDR_T2, 32'h500, 40);
        measure(8'h00, `TMROV_ADDR_T3, 32'h50000, 40);
        done("clocks");
        // Select bit set yet counter mode must ignore it
        wr(`TMROV_ADDR_CLKCTL, 32'h04);
        for (int i = 0; i < 4; i++) begin
            v[i] = 16'($random(seed)) & 16'h7fff;
            n[i] = 5 + ($random(seed) & 15);
            wr(ta[i], {16'h0, v[i]});
        end
        wr(`TMROV_ADDR_MODE, 32'h0019_09dd);
        fork
            src0.send(n[0]);
            src1.send(n[1]);
            src2.send(n[2]);
            src3.send(n[3]);
        join
        repeat (8) @(posedge clock);
        wr(`TMROV_ADDR_MODE, 32'h0);
        for (int i = 0; i < 4; i++) begin
            rd(ta[i]);
            `CHK(d, ({16'h0, v[i] + 16'(n[i])}))
        end
        rd(`TMROV_ADDR_CAP3);
        `CHK(d, ({16'h0, v[3] + 16'(n[3] - 1)}))
        done("events");
        for (int m = 1; m >= 0; m--) begin
            wr(`TMROV_ADDR_MASK, 32'(m));
            wr(`TMROV_ADDR_T0, 32'hfff0);
            wr(`TMROV_ADDR_MODE, 32'h09);
            repeat (30) @(posedge clock);
            #1;
            `CHK(irq, 1'(m))
            wr(`TMROV_ADDR_MODE, 32'h0);
            rd(`TMROV_ADDR_STATUS);
            `CHK(d[0], 1'b1)
            `CHK(irq, 1'b0)
        end
        done("overflow");
        wr(`TMROV_ADDR_CLKCTL, 32'h10);
        wr(`TMROV_ADDR_T2RLD, 32'hff00);
        wr(`TMROV_ADDR_T2, 32'hfff8);
        wr(`TMROV_ADDR_MODE, 32'h100);
        repeat (20) @(posedge clock);
        wr(`TMROV_ADDR_MODE, 32'h0);
        rd(`TMROV_ADDR_T2);
        `CHK(near(d, 32'hff0e, 6), 1'b1)
        rd(`TMROV_ADDR_STATUS);
        `CHK(d[3], 1'b1)
        done("reload");
        close_out();
    end
endmodule
`default_nettype wire
